// ==== design/e1rs_pkg.sv ====
package e1rs_pkg;

	// register indices as printed; byte address is index times four
	localparam logic [7:0] IDX_PRBS_ERR      = 8'h10;
	localparam logic [7:0] IDX_PRBS_MF_CNT   = 8'h11;
	localparam logic [7:0] IDX_ALARM_LATCH   = 8'h12;
	localparam logic [7:0] IDX_FAS_ERR_CNT   = 8'h13;
	localparam logic [7:0] IDX_EBIT_HIGH     = 8'h14;
	localparam logic [7:0] IDX_EBIT_LOW      = 8'h15;
	localparam logic [7:0] IDX_BPV_HIGH      = 8'h16;
	localparam logic [7:0] IDX_BPV_LOW       = 8'h17;
	localparam logic [7:0] IDX_CRC_HIGH      = 8'h18;
	localparam logic [7:0] IDX_CRC_LOW       = 8'h19;
	localparam logic [7:0] IDX_IRQ_WORD0     = 8'h1b;
	localparam logic [7:0] IDX_IRQ_MASK0     = 8'h20;

	// alarm latch bit positions
	localparam int ALM_REMOTE   = 7;
	localparam int ALM_ALL_ONES = 6;
	localparam int ALM_TS16     = 5;
	localparam int ALM_LOSS     = 4;
	localparam int ALM_AUXILIARY_PATTERN_LATCH     = 3;
	localparam int ALM_MULTIFRAME_ALARM_LATCH    = 2;
	localparam int ALM_SLIP     = 1;

	// interrupt word zero bit positions
	localparam int IRQ_FSYNC    = 7;
	localparam int IRQ_MFSYNC   = 6;
	localparam int IRQ_CRCSYNC  = 5;
	localparam int IRQ_ALL_ONES = 4;
	localparam int IRQ_LOSS     = 3;
	localparam int IRQ_CEF      = 2;
	localparam int IRQ_YBIT     = 1;
	localparam int IRQ_SLIP     = 0;

	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [7:0]  RST_MASK  = 8'h00;
	localparam logic [9:0]  RST_10    = 10'h000;
	localparam logic [15:0] RST_16    = 16'h0000;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;

	// per-event strobes and levels from framer, line interface and slip buffer
	typedef struct packed {
		logic crc_multiframe;
		logic remote_alarm;
		logic all_ones;
		logic ts16_all_ones;
		logic digital_loss;
		logic auxiliary_pattern;
		logic multiframe_alarm;
		logic rx_slip;
		logic fas_errored;
		logic ebit_error;
		logic bipolar_violation;
		logic crc4_error;
		logic frame_sync;
		logic multiframe_sync;
		logic crc4_sync;
		logic signal_loss;
		logic multiframe_align_loss;
	} e1rs_evt_t;

	typedef struct packed {
		logic [7:0]  prbs_multiframe_tally;
		logic [7:0]  alarm_latch;
		logic [7:0]  frame_align_error_tally;
		logic [9:0]  ebit_error_tally;
		logic [15:0] bipolar_violation_tally;
		logic [9:0]  crc4_error_tally;
		logic [7:0]  irq_word;
		logic [7:0]  irq_mask;
		logic        fas_prev_err;
		logic [4:0]  level_prev;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} e1rs_state_t;

endpackage : e1rs_pkg

// ==== design/e1rs_status_bank.sv ====
`timescale 1ns/10ps
`default_nettype none

module e1rs_status_bank
	import e1rs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire e1rs_evt_t   evt
);

	////////////////////////////////////////////////////////////////////////////
	e1rs_state_t s_q;
	e1rs_state_t s_d;

	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		hit = (a == {2'b00, idx, 2'b00});
	endfunction : hit

	logic       setup;
	logic       rd_fire;
	logic       wr_fire;
	logic [7:0] rbyte;
	logic       mapped;
	logic [7:0] alm_set;
	logic [7:0] irq_set;
	logic [4:0] lvl_now;

	// no wait state: setup cycle decodes, access cycle answers
	assign setup   = psel & ~penable;
	assign rd_fire = psel & penable & s_q.pready & ~pwrite;
	assign wr_fire = psel & penable & s_q.pready & pwrite;

	always_comb begin
		lvl_now = {evt.frame_sync, evt.multiframe_sync, evt.crc4_sync, evt.all_ones,
			evt.multiframe_align_loss};
		alm_set = 8'h00;
		alm_set[ALM_REMOTE]   = evt.remote_alarm;
		alm_set[ALM_ALL_ONES] = evt.all_ones;
		alm_set[ALM_TS16]     = evt.ts16_all_ones;
		alm_set[ALM_LOSS]     = evt.digital_loss;
		alm_set[ALM_AUXILIARY_PATTERN_LATCH]     = evt.auxiliary_pattern;
		alm_set[ALM_MULTIFRAME_ALARM_LATCH]    = evt.multiframe_alarm;
		alm_set[ALM_SLIP]     = evt.rx_slip;
		irq_set = 8'h00;
		irq_set[IRQ_FSYNC]    = lvl_now[4] ^ s_q.level_prev[4];
		irq_set[IRQ_MFSYNC]   = lvl_now[3] ^ s_q.level_prev[3];
		irq_set[IRQ_CRCSYNC]  = lvl_now[2] ^ s_q.level_prev[2];
		irq_set[IRQ_ALL_ONES] = lvl_now[1] ^ s_q.level_prev[1];
		irq_set[IRQ_LOSS]     = evt.signal_loss;
		irq_set[IRQ_CEF]      = evt.fas_errored & s_q.fas_prev_err;
		irq_set[IRQ_YBIT]     = lvl_now[0] ^ s_q.level_prev[0];
		irq_set[IRQ_SLIP]     = evt.rx_slip;
		irq_set = irq_set & s_q.irq_mask;
	end

	always_comb begin
		mapped = 1'b1;
		rbyte  = RST_BYTE;
		if (hit(paddr, IDX_PRBS_ERR)) begin
			rbyte = RST_BYTE;
		end else if (hit(paddr, IDX_PRBS_MF_CNT)) begin
			rbyte = s_q.prbs_multiframe_tally;
		end else if (hit(paddr, IDX_ALARM_LATCH)) begin
			rbyte = s_q.alarm_latch;
		end else if (hit(paddr, IDX_FAS_ERR_CNT)) begin
			rbyte = s_q.frame_align_error_tally;
		end else if (hit(paddr, IDX_EBIT_HIGH)) begin
			rbyte = {6'b000000, s_q.ebit_error_tally[9:8]};
		end else if (hit(paddr, IDX_EBIT_LOW)) begin
			rbyte = s_q.ebit_error_tally[7:0];
		end else if (hit(paddr, IDX_BPV_HIGH)) begin
			rbyte = s_q.bipolar_violation_tally[15:8];
		end else if (hit(paddr, IDX_BPV_LOW)) begin
			rbyte = s_q.bipolar_violation_tally[7:0];
		end else if (hit(paddr, IDX_CRC_HIGH)) begin
			rbyte = {6'b000000, s_q.crc4_error_tally[9:8]};
		end else if (hit(paddr, IDX_CRC_LOW)) begin
			rbyte = s_q.crc4_error_tally[7:0];
		end else if (hit(paddr, IDX_IRQ_WORD0)) begin
			rbyte = s_q.irq_word;
		end else if (hit(paddr, IDX_IRQ_MASK0)) begin
			rbyte = s_q.irq_mask;
		end else begin
			mapped = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.pready  = setup;
		s_d.pslverr = setup & ~mapped;
		s_d.prdata  = RST_WORD;
		if (setup && !pwrite && mapped) begin
			s_d.prdata = {24'h00_0000, rbyte};
		end
		s_d.level_prev = lvl_now;
		if (evt.fas_errored) begin
			s_d.fas_prev_err = 1'b1;
		end else if (evt.crc_multiframe | evt.frame_sync) begin
			s_d.fas_prev_err = s_d.fas_prev_err;
		end
		// a clean fas is signalled by a frame with no error strobe; keep last result
		// counters wrap; overflow reporting lives elsewhere
		if (evt.crc_multiframe) begin
			s_d.prbs_multiframe_tally = s_q.prbs_multiframe_tally + 8'h01;
		end
		if (wr_fire && hit(paddr, IDX_PRBS_ERR) && pstrb[0]) begin
			s_d.prbs_multiframe_tally = RST_BYTE;
		end
		if (wr_fire && hit(paddr, IDX_IRQ_MASK0) && pstrb[0]) begin
			s_d.irq_mask = pwdata[7:0];
		end
		if (evt.fas_errored) begin
			s_d.frame_align_error_tally = s_q.frame_align_error_tally + 8'h01;
		end
		if (evt.ebit_error) begin
			s_d.ebit_error_tally = s_q.ebit_error_tally + 10'h001;
		end
		if (evt.bipolar_violation) begin
			s_d.bipolar_violation_tally = s_q.bipolar_violation_tally + 16'h0001;
		end
		if (evt.crc4_error) begin
			s_d.crc4_error_tally = s_q.crc4_error_tally + 10'h001;
		end
		// clear on read, then set: an event in the read cycle survives
		if (rd_fire && hit(paddr, IDX_ALARM_LATCH)) begin
			s_d.alarm_latch = RST_BYTE;
		end
		if (rd_fire && hit(paddr, IDX_IRQ_WORD0)) begin
			s_d.irq_word = RST_BYTE;
		end
		s_d.alarm_latch = s_d.alarm_latch | alm_set;
		s_d.irq_word    = s_d.irq_word | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.prbs_multiframe_tally   <= RST_BYTE;
			s_q.alarm_latch             <= RST_BYTE;
			s_q.frame_align_error_tally <= RST_BYTE;
			s_q.ebit_error_tally        <= RST_10;
			s_q.bipolar_violation_tally <= RST_16;
			s_q.crc4_error_tally        <= RST_10;
			s_q.irq_word                <= RST_BYTE;
			s_q.irq_mask                <= RST_MASK;
			s_q.fas_prev_err            <= 1'b0;
			s_q.level_prev              <= 5'b00000;
			s_q.prdata                  <= RST_WORD;
			s_q.pready                  <= 1'b0;
			s_q.pslverr                 <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata  = s_q.prdata;
	assign pready  = s_q.pready;
	assign pslverr = s_q.pslverr;

endmodule : e1rs_status_bank

`default_nettype wire

// ==== tb/e1rs_status_bank_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module e1rs_status_bank_assertions
	import e1rs_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire e1rs_evt_t   evt
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic rd_acc = pready && !pwrite;
	////////////////
	property p_answer; psel && !penable |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("setup not answered");
	property p_quiet; !psel |=> !pready && prdata == 32'h0000_0000; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without request");
	property p_stand; pready |=> !pready; endproperty
	a_stand: assert property (p_stand) else $error("ready held too long");
	property p_upper; pready |-> prdata[31:8] == 24'h00_0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bytes set");
	property p_unused0; rd_acc && paddr == 12'h048 |-> !prdata[0] && !pslverr; endproperty
	a_unused0: assert property (p_unused0) else $error("latch bit0 set");
	property p_high2; pready && (paddr == 12'h050 || paddr == 12'h060) |-> prdata[7:2] == 6'h00;
	endproperty
	a_high2: assert property (p_high2) else $error("high tally bits set");
	// event seen three edges back: latched, then captured at setup, shown at access
	property p_remote; $past(evt.remote_alarm, 3) && rd_acc && paddr == 12'h048 |-> prdata[7];
	endproperty
	a_remote: assert property (p_remote) else $error("remote alarm lost");
	sequence s_clr;
		(pready && pwrite && paddr == 12'h040 && !evt.crc_multiframe) ##1 !evt.crc_multiframe
		##1 (psel && !penable && !pwrite && paddr == 12'h044 && !evt.crc_multiframe) ##1 pready;
	endsequence
	property p_prbs; s_clr |-> prdata[7:0] == 8'h00; endproperty
	a_prbs: assert property (p_prbs) else $error("tally not zeroed");
	// index 0x1a is a hole in the map
	property p_refused; pready && paddr == 12'h068 |-> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_refused: assert property (p_refused) else $error("hole not refused");
	c_remote: cover property (p_remote);
	c_prbs: cover property (s_clr);
	c_refused: cover property (pready && pslverr);
endmodule : e1rs_status_bank_assertions
bind e1rs_status_bank e1rs_status_bank_assertions u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .evt(evt));
`default_nettype wire

// ==== tb/e1rs_apb_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module e1rs_apb_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	output logic      [3:0]  pstrb
);
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
	end
	// request frozen until pready seen at an edge; no cycle count assumed
	task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : e1rs_apb_host
`default_nettype wire

// ==== tb/e1rs_status_bank_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module e1rs_status_bank_tb
	import e1rs_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [3:0]  pstrb;
	e1rs_evt_t   evt;
	int          mismatches, cmp_count;
	int          pos [8] = '{4, 3, 2, 14, 1, 8, 0, 9};
	e1rs_apb_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb));
	e1rs_status_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .evt(evt));
	////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task rd(input logic [7:0] idx, input logic [31:0] exp, input logic err);
		host.xfer(1'b0, idx, 32'h0000_0000, rv, re);
		chk(rv, exp);
		chk({31'h0, re}, {31'h0, err});
	endtask : rd
	task wr(input logic [7:0] idx, input logic [31:0] d);
		host.xfer(1'b1, idx, d, rv, re);
		chk({31'h0, re}, 32'h0000_0000);
	endtask : wr
	// one event input high for n edges
	task pulse(input int p, input int n);
		@(posedge pclk);
		evt <= e1rs_evt_t'(17'h0_0001 << p);
		repeat (n) @(posedge pclk);
		evt <= '0;
	endtask : pulse
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	////////////////
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		#200000;
		mismatches++;
		finish_test();
	end
	initial begin
		evt = '0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 8'h11; i <= 8'h1b; i++) rd(8'(i), 32'h0000_0000, i == 8'h1a);
		pulse(16, 3);
		rd(IDX_PRBS_MF_CNT, 32'h0000_0003, 1'b0);
		wr(IDX_PRBS_ERR, 32'h0000_0001);
		rd(IDX_PRBS_MF_CNT, 32'h0000_0000, 1'b0);
		pulse(8, 2);
		rd(IDX_FAS_ERR_CNT, 32'h0000_0002, 1'b0);
		pulse(7, 259);
		rd(IDX_EBIT_HIGH, 32'h0000_0001, 1'b0);
		rd(IDX_EBIT_LOW, 32'h0000_0003, 1'b0);
		pulse(6, 300);
		rd(IDX_BPV_HIGH, 32'h0000_0001, 1'b0);
		rd(IDX_BPV_LOW, 32'h0000_002c, 1'b0);
		pulse(5, 260);
		rd(IDX_CRC_HIGH, 32'h0000_0001, 1'b0);
		rd(IDX_CRC_LOW, 32'h0000_0004, 1'b0);
		for (int b = 7; b >= 1; b--) begin
			pulse(b + 8, 1);
			rd(IDX_ALARM_LATCH, 32'(1 << b), 1'b0);
			rd(IDX_ALARM_LATCH, 32'h0000_0000, 1'b0);
		end
		wr(IDX_IRQ_MASK0, 32'h0000_007f);
		pulse(4, 1);
		rd(IDX_IRQ_WORD0, 32'h0000_0000, 1'b0);
		wr(IDX_IRQ_MASK0, 32'h0000_00ff);
		for (int i = 0; i < 8; i++) begin
			pulse(pos[i], 1);
			rd(IDX_IRQ_WORD0, 32'(1 << (7 - i)), 1'b0);
			rd(IDX_IRQ_WORD0, 32'h0000_0000, 1'b0);
		end
		finish_test();
	end
endmodule : e1rs_status_bank_tb
`default_nettype wire
